// >>> isf_bus_model.sv
`timescale 1ns/1ps
// Other masters on the two wire bus; lines idle high through pull-ups
module isf_bus_model (
	output logic scl_out,
	output logic sda_out
);
	// ****
	// Line drivers, half link period 400 ns
	// ****
	// Clock stands still between frames, so only edges inside a frame
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Start: data falls while clock is high, then clock drops
	// Non-blocking, as steps can land on a system clock edge
	task gen_start();
		sda_out <= 1'b1;
		#400 scl_out <= 1'b1;
		#400 sda_out <= 1'b0;
		#400 scl_out <= 1'b0;
	endtask
	// Stop: data rises while clock is high, bus left idle
	task gen_stop();
		sda_out <= 1'b0;
		#400 scl_out <= 1'b1;
		#400 sda_out <= 1'b1;
		#400;
	endtask
endmodule

// >>> isf_pkg.sv
package isf_pkg;
	// ****************************************************
	// Register indices; byte address is four times these
	// ****************************************************
	localparam logic [7:0] IDX_CTRL = 8'h5F;
	localparam logic [7:0] IDX_SR1 = 8'h5E;
	localparam logic [7:0] IDX_SR2 = 8'h5D;
	localparam logic [7:0] IDX_BUF = 8'h59;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int B_EVF = 7;
	localparam int B_HDR = 6;
	localparam int B_DIR = 5;
	localparam int B_BUSY = 4;
	localparam int B_BTF = 3;
	localparam int B_ADDRESS_MATCH_FLAG = 2;
	localparam int B_MST = 1;
	localparam int B_SB = 0;
	localparam int B_AF = 4;
	localparam int B_STOP_SEEN_FLAG = 3;
	localparam int B_ARBITRATION_LOST_FLAG = 2;
	localparam int B_BUS_ERROR_FLAG = 1;
	localparam int B_GENERAL_CALL_FLAG = 0;
	localparam int B_PE = 5;
	localparam int B_GENERAL_CALL_ENABLE = 4;
	localparam int B_START = 3;
	localparam int B_ACK = 2;
	localparam int B_STOP = 1;
	localparam int B_ITE = 0;
	localparam logic [7:0] CTRL_MASK = 8'h3F;

	// Event pulses and levels from the bus engine, same clock
	typedef struct packed {
		logic start_done;
		logic hdr_sent;
		logic addr_sent;
		logic tx_acked;
		logic rx_done;
		logic rx_ack_sent;
		logic ack_fail;
		logic arb_lost;
		logic addr_match;
		logic gc_seen;
		logic byte_active;
		logic [7:0] rx_data;
	} isf_evt_s;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] dbyte;
		logic summary_event_flag, hdr, dir, busy, byte_done_flag, address_match_flag, mst, sb, addr_pend;
		logic af, stop_seen_flag, arbitration_lost_flag, bus_error_flag, general_call_flag, acked, rd1, rd2;
		logic scl_s1, scl_s2, sda_s1, sda_s2, sda_p;
		logic [31:0] prdata;
		logic pready, pslverr, irq, hold, tx_load;
	} isf_st_s;
endpackage

// >>> isf_status.sv
`timescale 1ns/1ps
// How it works
// - Summary flag set by any flagged event but general call
// - Summary clears with its underlying event flags
// - Header flag cleared by second-status read, buffer write
// - Direction shows transmit or receive with byte-done
// - Direction cleared on stop, arbitration loss, disable
// - Busy follows bus start and stop, always
// - Byte-done cleared by first-status read, buffer access
// - Transmit byte-done after ack; address via address event
// - Receive byte-done after ack pulse sent; at receive end when ack is off
// - Clock held low while byte-done set and no error flag stands
// - Address match in slave mode, holds clock
// - Master flag on start request; cleared stop/loss/disable
// - Start flag cleared by first-status read, buffer write
// - Ack failure cleared by second-status read
// - Slave stop after acknowledge sets stop flag when ack is on
// - Arbitration loss sets flag, drops to slave
// - Misplaced start or stop sets bus error
// - Error flags never stretch the clock
// - General call flag; cleared on stop, disable
// - Top three error-status bits read zero; reset zero
// - Disable clears all flags except busy
module isf_status
	import isf_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire isf_evt_s evt_in,
	output logic scl_hold_out,
	output logic irq_out,
	output logic [7:0] ctrl_out,
	output logic [7:0] tx_byte_out,
	output logic tx_load_out
);
	isf_st_s s;
	isf_st_s next_s;
	logic start_det, stop_det, acc, rd_sr1, rd_sr2, wr_cr, dr_any, dr_wr;
	logic clr_btf, set_btf, ack_en;
	logic [3:0] hit;

	// ****************************************************
	// Decode helpers
	// ****************************************************
	// One-hot {buffer, control, status2, status1}; zero if unmapped
	function automatic logic [3:0] dec(input logic [11:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a[1:0] == 2'h0)
		begin
			r[0] = (a[9:2] == IDX_SR1) && (a[11:10] == 2'h0);
			r[1] = (a[9:2] == IDX_SR2) && (a[11:10] == 2'h0);
			r[2] = (a[9:2] == IDX_CTRL) && (a[11:10] == 2'h0);
			r[3] = (a[9:2] == IDX_BUF) && (a[11:10] == 2'h0);
		end
		return r;
	endfunction

	function automatic logic [7:0] sr1_val(input isf_st_s t);
		logic [7:0] v;
		v = RST_BYTE;
		v[B_EVF] = t.summary_event_flag;
		v[B_HDR] = t.hdr;
		v[B_DIR] = t.dir;
		v[B_BUSY] = t.busy;
		v[B_BTF] = t.byte_done_flag;
		v[B_ADDRESS_MATCH_FLAG] = t.address_match_flag;
		v[B_MST] = t.mst;
		v[B_SB] = t.sb;
		return v;
	endfunction

	// Bits 7:5 stay at the reset value, i.e. zero
	function automatic logic [7:0] sr2_val(input isf_st_s t);
		logic [7:0] v;
		v = RST_BYTE;
		v[B_AF] = t.af;
		v[B_STOP_SEEN_FLAG] = t.stop_seen_flag;
		v[B_ARBITRATION_LOST_FLAG] = t.arbitration_lost_flag;
		v[B_BUS_ERROR_FLAG] = t.bus_error_flag;
		v[B_GENERAL_CALL_FLAG] = t.general_call_flag;
		return v;
	endfunction

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb
	begin
		next_s = s;
		// Two-flop synchronisers; edge detect compares the second stage with the delayed sda_p stage
		next_s.scl_s1 = scl_in;
		next_s.scl_s2 = s.scl_s1;
		next_s.sda_s1 = sda_in;
		next_s.sda_s2 = s.sda_s1;
		next_s.sda_p = s.sda_s2;
		start_det = s.scl_s2 && s.sda_p && !s.sda_s2;
		stop_det = s.scl_s2 && !s.sda_p && s.sda_s2;

		// Access phase completes in the cycle pready is high
		acc = psel_in && penable_in && s.pready;
		hit = dec(paddr_in) & {4{acc}};
		rd_sr1 = hit[0] && !pwrite_in;
		rd_sr2 = hit[1] && !pwrite_in;
		wr_cr = hit[2] && pwrite_in;
		dr_any = hit[3];
		dr_wr = hit[3] && pwrite_in;
		ack_en = s.ctrl[B_ACK];

		// Remember a status read until the access that completes it
		next_s.rd1 = rd_sr1 || (s.rd1 && !(dr_any || wr_cr));
		next_s.rd2 = rd_sr2 || (s.rd2 && !dr_wr);
		clr_btf = s.rd1 && dr_any;

		// Byte done; set wins over a clear in the same cycle
		set_btf = evt_in.tx_acked || (evt_in.rx_ack_sent && ack_en)
			|| (evt_in.rx_done && !ack_en);
		next_s.byte_done_flag = set_btf || (s.byte_done_flag && !clr_btf);
		if (evt_in.tx_acked)
			next_s.dir = 1'b1;
		else if (set_btf)
			next_s.dir = 1'b0;
		else if (clr_btf || stop_det || evt_in.arb_lost)
			next_s.dir = 1'b0;

		// Busy is never gated by the enable
		next_s.busy = start_det || (s.busy && !stop_det);

		next_s.address_match_flag = (evt_in.addr_match && !s.mst) || (s.address_match_flag && !rd_sr1);
		// Loss or stop wins over a start request still pending in control
		next_s.mst = ((s.ctrl[B_START] && !s.busy) || s.mst)
			&& !(stop_det || evt_in.arb_lost);
		next_s.sb = evt_in.start_done || (s.sb && !(s.rd1 && dr_wr));
		next_s.hdr = evt_in.hdr_sent || (s.hdr && !(s.rd2 && dr_wr));
		// Address phase event; the address byte itself never sets byte done
		next_s.addr_pend = evt_in.addr_sent || (s.addr_pend && !(s.rd1 && wr_cr));

		// Error flags, each but general call cleared by reading the second status register
		next_s.af = evt_in.ack_fail || (s.af && !rd_sr2);
		next_s.stop_seen_flag = (stop_det && !s.mst && ack_en && s.acked)
			|| (s.stop_seen_flag && !rd_sr2);
		next_s.arbitration_lost_flag = evt_in.arb_lost || (s.arbitration_lost_flag && !rd_sr2);
		next_s.bus_error_flag = ((start_det || stop_det) && evt_in.byte_active)
			|| (s.bus_error_flag && !rd_sr2);
		next_s.general_call_flag = (evt_in.gc_seen && s.ctrl[B_GENERAL_CALL_ENABLE]) || (s.general_call_flag && !stop_det);
		// An acknowledge since the last start or stop qualifies the stop flag
		next_s.acked = evt_in.rx_ack_sent || evt_in.tx_acked
			|| (s.acked && !(start_det || stop_det));

		// Control: while disabled only enable and stop take a write
		if (wr_cr && s.ctrl[B_PE])
			next_s.ctrl = pwdata_in[7:0] & CTRL_MASK;
		else if (wr_cr)
		begin
			next_s.ctrl[B_PE] = pwdata_in[B_PE];
			next_s.ctrl[B_STOP] = pwdata_in[B_STOP];
		end
		else if (evt_in.start_done)
			next_s.ctrl[B_START] = 1'b0;

		// Byte buffer: software write or received byte
		if (dr_wr)
			next_s.dbyte = pwdata_in[7:0];
		else if (evt_in.rx_done)
			next_s.dbyte = evt_in.rx_data;
		next_s.tx_load = dr_wr;

		// Disabled: all flags but busy, and control but the stop bit, are cleared
		if (!next_s.ctrl[B_PE])
		begin
			next_s.ctrl = next_s.ctrl & (8'h01 << B_STOP);
			{next_s.hdr, next_s.dir, next_s.byte_done_flag, next_s.address_match_flag} = 4'h0;
			{next_s.mst, next_s.sb, next_s.addr_pend} = 3'h0;
			{next_s.af, next_s.stop_seen_flag, next_s.arbitration_lost_flag} = 3'h0;
			{next_s.bus_error_flag, next_s.general_call_flag} = 2'h0;
		end

		// Summary is rebuilt from the flags, so each clear path clears it
		next_s.summary_event_flag = next_s.byte_done_flag || next_s.address_match_flag || next_s.sb || next_s.hdr
			|| next_s.addr_pend || next_s.af || next_s.stop_seen_flag
			|| next_s.arbitration_lost_flag || next_s.bus_error_flag;
		// Clock stretch on service events, never while an error stands
		next_s.hold = (next_s.byte_done_flag || next_s.address_match_flag || next_s.sb || next_s.hdr
			|| next_s.addr_pend) && !(next_s.af || next_s.stop_seen_flag
			|| next_s.arbitration_lost_flag || next_s.bus_error_flag);
		next_s.irq = next_s.summary_event_flag && next_s.ctrl[B_ITE];

		// Read data is captured in the setup cycle, zero wait states
		next_s.pready = psel_in && !penable_in;
		// Error stands only with ready, one cycle
		next_s.pslverr = psel_in && !penable_in && (dec(paddr_in) == 4'h0);
		if (psel_in && !penable_in)
		begin
			unique case (dec(paddr_in))
				4'h1: next_s.prdata = {24'h0, sr1_val(s)};
				4'h2: next_s.prdata = {24'h0, sr2_val(s)};
				4'h4: next_s.prdata = {24'h0, s.ctrl};
				4'h8: next_s.prdata = {24'h0, s.dbyte};
				default: next_s.prdata = 32'h0;
			endcase
		end
	end

	// ****************************************************
	// State register
	// ****************************************************
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		// Line stages reset to the idle high level so no false edge follows reset
		if (!rst_n_in)
		begin
			s <= '0;
			s.scl_s1 <= 1'b1;
			s.scl_s2 <= 1'b1;
			s.sda_s1 <= 1'b1;
			s.sda_s2 <= 1'b1;
			s.sda_p <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Outputs straight from the state flops
	assign prdata_out = s.prdata;
	assign pready_out = s.pready;
	assign pslverr_out = s.pslverr;
	assign scl_hold_out = s.hold;
	assign irq_out = s.irq;
	assign ctrl_out = s.ctrl;
	assign tx_byte_out = s.dbyte;
	assign tx_load_out = s.tx_load;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_tx_btf;
		evt_in.tx_acked && s.ctrl[B_PE] && !(wr_cr && !pwdata_in[B_PE]) |=> s.byte_done_flag && s.dir;
	endproperty
	a_tx_btf: assert property (p_tx_btf) else $error("tx ack did not set byte done");

	property p_rx_btf;
		evt_in.rx_ack_sent && ack_en && !evt_in.tx_acked && !wr_cr && s.ctrl[B_PE]
			|=> s.byte_done_flag && !s.dir;
	endproperty
	a_rx_btf: assert property (p_rx_btf) else $error("rx ack did not set byte done");

	property p_btf_clr;
		clr_btf && !set_btf |=> !s.byte_done_flag;
	endproperty
	a_btf_clr: assert property (p_btf_clr) else $error("byte done not cleared");

	property p_hold;
		s.byte_done_flag && !(s.af || s.stop_seen_flag || s.arbitration_lost_flag || s.bus_error_flag) |-> scl_hold_out;
	endproperty
	a_hold: assert property (p_hold) else $error("clock not held");

	property p_err_nohold;
		s.af || s.stop_seen_flag || s.arbitration_lost_flag || s.bus_error_flag |-> !scl_hold_out;
	endproperty
	a_err_nohold: assert property (p_err_nohold) else $error("clock held on error");

	property p_busy;
		start_det |=> s.busy ##1 s.busy [*2];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not tracking start");

	property p_af_clr;
		rd_sr2 && !evt_in.ack_fail |=> !s.af;
	endproperty
	a_af_clr: assert property (p_af_clr) else $error("ack failure not cleared");

	property p_arbitration_lost_flag;
		evt_in.arb_lost && s.ctrl[B_PE] && !wr_cr |=> s.arbitration_lost_flag && !s.mst && !s.dir;
	endproperty
	a_arbitration_lost_flag: assert property (p_arbitration_lost_flag) else $error("arbitration loss mishandled");

	property p_disabled;
		!s.ctrl[B_PE] |-> !(s.summary_event_flag || s.byte_done_flag || s.mst || s.af || s.general_call_flag || irq_out);
	endproperty
	a_disabled: assert property (p_disabled) else $error("flag set while disabled");

	property p_irq;
		irq_out |-> s.summary_event_flag && s.ctrl[B_ITE] && $past(next_s.summary_event_flag);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without event");

	property p_sr2_top;
		psel_in && !penable_in && dec(paddr_in) == 4'h2 |=> prdata_out[31:5] == 27'h0;
	endproperty
	a_sr2_top: assert property (p_sr2_top) else $error("status2 top bits set");

	c_btf_cycle: cover property (set_btf ##[1:50] clr_btf);
	c_start_seq: cover property (evt_in.start_done ##[1:50] (s.rd1 && dr_wr));
	c_err_read: cover property (s.bus_error_flag ##[1:50] rd_sr2);
	c_stop_flag: cover property (!s.stop_seen_flag ##1 s.stop_seen_flag);
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import isf_pkg::*;
	// ****
	// Signals
	// ****
	localparam int E_START = 18;
	localparam int E_HDR = 17;
	localparam int E_ADDR = 16;
	localparam int E_GC = 9;
	localparam int E_TXACK = 15;
	localparam int E_RXDONE = 14;
	localparam int E_RXACK = 13;
	localparam int E_AF = 12;
	localparam int E_ARBITRATION_LOST_FLAG = 11;
	localparam int E_ADDRESS_MATCH_FLAG = 10;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, bm_scl, bm_sda, hold, irq;
	logic [7:0] ctrl, tx_byte;
	isf_evt_s evt = '0;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	// Clock, 100 ns period
	always #50 clk_sys_in = ~clk_sys_in;
	isf_bus_model bm (.scl_out(bm_scl), .sda_out(bm_sda));
	// Stretch pulls the shared clock line low
	isf_status uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.scl_in(bm_scl & ~hold), .sda_in(bm_sda), .evt_in(evt), .scl_hold_out(hold),
		.irq_out(irq), .ctrl_out(ctrl), .tx_byte_out(tx_byte), .tx_load_out());
	// ****
	// Tasks
	// ****
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask
	// Gap first so status outputs have caught up before the setup edge
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		repeat (2) @(posedge clk_sys_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk_sys_in);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rdc(input logic [7:0] idx, input logic [7:0] exp, input string name);
		apb(1'b0, idx, 32'h0);
		chk(name, rd, {24'h0, exp});
	endtask
	// One cycle event pulse, then outputs settle off the edge
	task pulse(input int f, input logic [7:0] d);
		@(posedge clk_sys_in);
		evt <= isf_evt_s'((19'h1 << f) | d);
		@(posedge clk_sys_in);
		evt <= '0;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	// ****
	// Main sequence
	// ****
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rdc(IDX_SR1, 8'h00, "status1 reset");
		rdc(IDX_SR2, 8'h00, "status2 reset");
		apb(1'b0, 8'h00, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		// First enable write only takes the enable and stop bits
		apb(1'b1, IDX_CTRL, 32'h20);
		apb(1'b1, IDX_CTRL, 32'h2D);
		rdc(IDX_SR1, 8'h02, "master");
		pulse(E_START, 8'h00);
		chk("start hold", {31'h0, hold}, 32'h1);
		chk("start irq", {31'h0, irq}, 32'h1);
		chk("start bit cleared", {24'h0, ctrl}, 32'h25);
		rdc(IDX_SR1, 8'h83, "start sent");
		apb(1'b1, IDX_BUF, 32'h55);
		@(negedge clk_sys_in);
		chk("tx byte", {24'h0, tx_byte}, 32'h55);
		rdc(IDX_SR1, 8'h02, "start cleared");
		bm.gen_start();
		rdc(IDX_SR1, 8'h12, "busy set");
		pulse(E_TXACK, 8'h00);
		chk("tx hold", {31'h0, hold}, 32'h1);
		rdc(IDX_SR1, 8'hBA, "tx done");
		apb(1'b1, IDX_BUF, 32'h3C);
		rdc(IDX_SR1, 8'h12, "tx cleared");
		pulse(E_RXDONE, 8'hA5);
		rdc(IDX_SR1, 8'h12, "rx before ack");
		pulse(E_RXACK, 8'h00);
		rdc(IDX_SR1, 8'h9A, "rx done");
		rdc(IDX_BUF, 8'hA5, "rx byte");
		rdc(IDX_SR1, 8'h12, "rx cleared");
		pulse(E_AF, 8'h00);
		chk("af hold", {31'h0, hold}, 32'h0);
		rdc(IDX_SR1, 8'h92, "af summary");
		rdc(IDX_SR2, 8'h10, "af");
		rdc(IDX_SR1, 8'h12, "af summary cleared");
		pulse(E_ARBITRATION_LOST_FLAG, 8'h00);
		rdc(IDX_SR1, 8'h90, "arbitration_lost_flag slave");
		rdc(IDX_SR2, 8'h04, "arbitration_lost_flag");
		rdc(IDX_SR2, 8'h00, "arbitration_lost_flag cleared");
		// Start during a byte is misplaced
		@(posedge clk_sys_in);
		evt.byte_active <= 1'b1;
		bm.gen_start();
		@(posedge clk_sys_in);
		evt.byte_active <= 1'b0;
		chk("bus_error_flag hold", {31'h0, hold}, 32'h0);
		rdc(IDX_SR2, 8'h02, "bus_error_flag");
		rdc(IDX_SR2, 8'h00, "bus_error_flag cleared");
		bm.gen_stop();
		rdc(IDX_SR1, 8'h00, "busy cleared");
		pulse(E_ADDR, 8'h00);
		chk("address hold", {31'h0, hold}, 32'h1);
		rdc(IDX_SR1, 8'h80, "address event");
		apb(1'b1, IDX_CTRL, 32'h25);
		rdc(IDX_SR1, 8'h00, "address event passed");
		pulse(E_HDR, 8'h00);
		rdc(IDX_SR1, 8'hC0, "header sent");
		rdc(IDX_SR2, 8'h00, "header status2");
		apb(1'b1, IDX_BUF, 32'h12);
		rdc(IDX_SR1, 8'h00, "header cleared");
		apb(1'b1, IDX_CTRL, 32'h35);
		pulse(E_GC, 8'h00);
		rdc(IDX_SR2, 8'h01, "general call");
		bm.gen_start();
		bm.gen_stop();
		rdc(IDX_SR2, 8'h00, "general call stop");
		pulse(E_ADDRESS_MATCH_FLAG, 8'h00);
		chk("address_match_flag hold", {31'h0, hold}, 32'h1);
		apb(1'b1, IDX_CTRL, 32'h00);
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk("disable hold", {31'h0, hold}, 32'h0);
		rdc(IDX_SR1, 8'h00, "disable clears");
		bm.gen_start();
		rdc(IDX_SR1, 8'h10, "busy while disabled");
		bm.gen_stop();
		give_verdict();
	end
endmodule
